// ### hdl/hpm_host_decode.sv
// Purpose: Combinational decode of strap and host group select into pad functions.
// Assumes: Inputs are registered by the caller; outputs are registered by the caller.
// Notes:   Reserved codes park every host pad with no function selected.
`timescale 1ns/10ps
module hpm_host_decode (
	// Selection inputs
	input  wire logic              strap,
	input  wire logic [2:0]        hsel,
	// Decoded outputs
	output hpm_pkg::hpm_host_t     mux,
	output hpm_pkg::hpm_hfunc_t    func
);

	// Pick the block function from strap and select code
	always_comb begin
		func = hpm_pkg::HF_RSVD;
		if (strap) begin
			if (hsel == hpm_pkg::HSEL_BASE) begin
				func = hpm_pkg::HF_PCI;
			end
		end else begin
			case (hsel)
				hpm_pkg::HSEL_BASE:    func = hpm_pkg::HF_GPIO;
				hpm_pkg::HSEL_HPP:     func = hpm_pkg::HF_HPP;
				hpm_pkg::HSEL_SEL:     func = hpm_pkg::HF_SEL;
				hpm_pkg::HSEL_SEL_ETH: func = hpm_pkg::HF_SEL_ETH;
				hpm_pkg::HSEL_ETH:     func = hpm_pkg::HF_ETH;
				default:               func = hpm_pkg::HF_RSVD;
			endcase
		end
	end

	// Spread the function onto the per-pad select vectors
	always_comb begin
		mux = '0;
		case (func)
			hpm_pkg::HF_PCI: begin
				mux.pci = hpm_pkg::MASK_ALL;
			end
			hpm_pkg::HF_GPIO: begin
				mux.gpio = hpm_pkg::MASK_ALL;
			end
			// parallel port, first pad general purpose
			hpm_pkg::HF_HPP: begin
				mux.hpp  = hpm_pkg::MASK_HPP;
				mux.gpio = ~hpm_pkg::MASK_HPP;
			end
			// serial link, upper pads general purpose
			hpm_pkg::HF_SEL: begin
				mux.sel  = hpm_pkg::MASK_SEL;
				mux.gpio = hpm_pkg::MASK_ETH;
			end
			hpm_pkg::HF_SEL_ETH: begin
				mux.sel = hpm_pkg::MASK_SEL;
				mux.eth = hpm_pkg::MASK_ETH;
			end
			hpm_pkg::HF_ETH: begin
				mux.eth  = hpm_pkg::MASK_ETH;
				mux.gpio = hpm_pkg::MASK_SEL;
			end
			default: begin
				mux = '0;
			end
		endcase
	end

endmodule

// ### hdl/hpm_pin_mux.sv
// Purpose: Host, PCI data and general-purpose pad group selection with Wishbone registers.
// Assumes: Single clock; strap pin static while the device runs.
// Notes:   All outputs are registered; mux outputs follow a register change by one cycle.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module hpm_pin_mux #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Configuration strap and MAC state
	input  wire logic              pci_strap_pin,
	input  wire logic              eth_mac_in_reset,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Host group pad controls
	output hpm_pkg::hpm_host_t     host_mux,
	output logic      [26:0]       host_pull_en,
	output logic                   host_pwdn,
	// Small group pad controls
	output hpm_pkg::hpm_small_t    small_ctl,
	output logic                   gpg_pwdn,
	// Ethernet pin set selects
	output logic                   eth_mii_sel,
	output logic                   eth_rmii_sel
);

	// Register state, bus handshake and decoded pad controls
	logic                   strap_r;     // Captured strap level
	logic                   strap_cap_r; // Strap has been captured
	logic [2:0]             hsel_r;      // host_group_select
	logic                   rmii_r;      // Reduced-MII enable
	logic [1:0]             pwdn_r;      // io_pad_power_down fields
	logic                   fault_r;     // Ethernet selected while MAC ran
	logic                   ack_r;       // Wishbone acknowledge
	logic [31:0]            rdat_r;      // Wishbone read data
	hpm_pkg::hpm_host_t     mux_nxt;     // Decoded host pad functions
	hpm_pkg::hpm_hfunc_t    func_nxt;    // Decoded host function
	hpm_pkg::hpm_hfunc_t    func_r;      // Registered host function
	hpm_pkg::hpm_host_t     mux_r;       // Registered host pad functions
	logic [26:0]            pull_r;      // Host pull enables
	hpm_pkg::hpm_small_t    small_r;     // Small group controls
	logic                   req;         // Request present
	logic                   wr_go;       // Write takes effect this edge
	logic                   eth_on_nxt;  // Write leaves Ethernet pins selected
	logic [2:0]             wr_hsel;     // Select value after this write
	logic                   wr_rmii;     // Reduced-MII value after this write

	// Bus qualifiers; a write lands only on the edge that sees ack, so it lands once
	assign req   = wb_cyc_i && wb_stb_i;
	assign wr_go = req && wb_we_i && ack_r && wb_sel_i[0];

	// Strap capture once after reset release, then frozen
	// strap read only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_r     <= 1'b0;
			strap_cap_r <= 1'b0;
		end else if (!strap_cap_r) begin
			strap_r     <= pci_strap_pin;
			strap_cap_r <= 1'b1;
		end
	end

	// Wishbone acknowledge, one per request, dropped the cycle after
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end

	// Select register writes, taken at the edge where ack is seen
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hsel_r <= hpm_pkg::HSEL_RST;
			rmii_r <= hpm_pkg::RMII_RST;
		end else if (wr_go && wb_adr_i == hpm_pkg::SEL_ONE_ADDR) begin
			// Strap bit is not writable
			hsel_r <= wb_dat_i[hpm_pkg::HSEL_MSB:hpm_pkg::HSEL_LSB];
		end else if (wr_go && wb_adr_i == hpm_pkg::SEL_ZERO_ADDR) begin
			rmii_r <= wb_dat_i[hpm_pkg::RMII_BIT];
		end
	end

	// Pad power-down register; both groups come up powered after reset
	// host pad power
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwdn_r <= hpm_pkg::PWDN_RST;
		end else if (wr_go && wb_adr_i == hpm_pkg::PWDN_ADDR) begin
			pwdn_r[hpm_pkg::PWDN_HOST_BIT] <= wb_dat_i[hpm_pkg::PWDN_HOST_BIT];
			pwdn_r[hpm_pkg::PWDN_GPG_BIT]  <= wb_dat_i[hpm_pkg::PWDN_GPG_BIT];
		end
	end

	// Selection state that a write would leave behind
	always_comb begin
		wr_hsel = hsel_r;
		wr_rmii = rmii_r;
		if (wr_go && wb_adr_i == hpm_pkg::SEL_ONE_ADDR) begin
			wr_hsel = wb_dat_i[hpm_pkg::HSEL_MSB:hpm_pkg::HSEL_LSB];
		end else if (wr_go && wb_adr_i == hpm_pkg::SEL_ZERO_ADDR) begin
			wr_rmii = wb_dat_i[hpm_pkg::RMII_BIT];
		end
		eth_on_nxt = wr_rmii || (!strap_r && (wr_hsel == hpm_pkg::HSEL_SEL_ETH ||
			wr_hsel == hpm_pkg::HSEL_ETH));
	end

	// Sticky fault: a select write enables Ethernet pins while the MAC runs
	// MAC reset check
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fault_r <= 1'b0;
		end else if (wr_go && eth_on_nxt && !eth_mac_in_reset &&
			(wb_adr_i == hpm_pkg::SEL_ONE_ADDR || wb_adr_i == hpm_pkg::SEL_ZERO_ADDR)) begin
			// Set wins over any clear
			fault_r <= 1'b1;
		end else if (wr_go && wb_adr_i == hpm_pkg::STAT_ADDR &&
			wb_dat_i[hpm_pkg::FAULT_BIT]) begin
			fault_r <= 1'b0;
		end
	end

	// Read data, captured as ack rises; unmapped reads give zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdat_r <= 32'h0000_0000;
		end else if (req && !ack_r) begin
			rdat_r <= 32'h0000_0000;
			if (wb_adr_i == hpm_pkg::SEL_ONE_ADDR) begin
				rdat_r[hpm_pkg::STRAP_BIT]                  <= strap_r;
				rdat_r[hpm_pkg::HSEL_MSB:hpm_pkg::HSEL_LSB] <= hsel_r;
			end else if (wb_adr_i == hpm_pkg::SEL_ZERO_ADDR) begin
				rdat_r[hpm_pkg::RMII_BIT] <= rmii_r;
			end else if (wb_adr_i == hpm_pkg::PWDN_ADDR) begin
				rdat_r[1:0] <= pwdn_r;
			end else if (wb_adr_i == hpm_pkg::STAT_ADDR) begin
				rdat_r[hpm_pkg::STATE_MSB:hpm_pkg::STATE_LSB] <= func_r;
				rdat_r[hpm_pkg::FAULT_BIT]                    <= fault_r;
			end
		end
	end

	// Host group decode
	hpm_host_decode u_dec (
		.strap (strap_r),
		.hsel  (hsel_r),
		.mux   (mux_nxt),
		.func  (func_nxt)
	);

	// Register host pad functions and pulls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mux_r  <= '0;
			func_r <= hpm_pkg::HF_RSVD;
			pull_r <= '0;
		end else begin
			mux_r  <= mux_nxt;
			func_r <= func_nxt;
			pull_r <= {hpm_pkg::HOST_PINS{~strap_r}};
		end
	end

	// Register small group controls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			small_r <= '0;
		end else begin
			small_r.pcid_pull_en <= ~strap_r;
			small_r.gpg_pci  <= {hpm_pkg::GPG_PINS{strap_r}};
			small_r.gpg_gpio <= {hpm_pkg::GPG_PINS{~strap_r}};
			small_r.gpg_pull_en <= {hpm_pkg::GPG_PINS{~strap_r}};
		end
	end

	// Ethernet pin set selects
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			eth_mii_sel  <= 1'b0;
			eth_rmii_sel <= 1'b0;
		end else begin
			eth_mii_sel  <= (func_nxt == hpm_pkg::HF_SEL_ETH) || (func_nxt == hpm_pkg::HF_ETH);
			eth_rmii_sel <= rmii_r;
		end
	end

	// Every output is a flip-flop or a bit of one
	assign wb_ack_o     = ack_r;
	assign wb_dat_o     = rdat_r;
	assign host_mux     = mux_r;
	assign host_pull_en = pull_r;
	assign host_pwdn    = pwdn_r[hpm_pkg::PWDN_HOST_BIT];
	assign small_ctl    = small_r;
	assign gpg_pwdn     = pwdn_r[hpm_pkg::PWDN_GPG_BIT];

	// Checks run on the bus clock; reset aborts any attempt in flight
	// Pad checks wait for the strap capture; only pad_power_rst_a judges reset values, the pad power at capture
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	pci_route_a: assert property (
		(strap_cap_r && strap_r && hsel_r == 3'h0) |=>
		(host_mux.pci == 27'h7FF_FFFF && host_mux.gpio == '0))
		else $error("host pads not routed to PCI");
	gpio_default_a: assert property (
		(strap_cap_r && !strap_r && hsel_r == 3'h0) |=>
		(host_mux.gpio == 27'h7FF_FFFF && host_mux.pci == '0))
		else $error("host pads not all general purpose");
	hpp_mode_a: assert property (
		(!strap_r && hsel_r == 3'h1) |=> (host_mux.gpio == 27'h000_0001 &&
		host_mux.hpp == 27'h7FF_FFFE))
		else $error("parallel port selection wrong");
	sel_mode_a: assert property (
		(!strap_r && hsel_r == 3'h2) |=> (host_mux.sel == 27'h000_03FF &&
		host_mux.gpio == 27'h7FF_FC00 && !eth_mii_sel))
		else $error("serial link selection wrong");
	sel_eth_a: assert property (
		(!strap_r && hsel_r == 3'h3) |=> (host_mux.sel == 27'h000_03FF &&
		host_mux.eth == 27'h7FF_FC00 && eth_mii_sel))
		else $error("serial link with Ethernet wrong");
	eth_mode_a: assert property (
		(!strap_r && hsel_r == 3'h4) |=> (host_mux.eth == 27'h7FF_FC00 &&
		host_mux.gpio == 27'h000_03FF))
		else $error("Ethernet selection wrong");
	host_pull_a: assert property (
		strap_cap_r |=> (host_pull_en == {27{~$past(strap_r)}}))
		else $error("host pull enables do not follow strap");
	strap_ro_a: assert property (
		strap_cap_r |=> $stable(strap_r) ##1 $stable(strap_r))
		else $error("strap field changed after capture");
	host_pwdn_a: assert property (
		(wr_go && wb_adr_i == 8'h08) |=> (host_pwdn == $past(wb_dat_i[0])))
		else $error("host power-down write not applied");
	pcid_pull_a: assert property (
		strap_cap_r |=> (small_ctl.pcid_pull_en != $past(strap_r)))
		else $error("PCI data pulls wrong");
	gpg_route_a: assert property (
		strap_r [*2] |-> (small_ctl.gpg_pci == 4'hF && small_ctl.gpg_gpio == 4'h0))
		else $error("general group not routed to PCI");
	gpg_pull_a: assert property (
		(!strap_r && strap_cap_r) [*2] |-> (small_ctl.gpg_pull_en == 4'hF))
		else $error("general group pulls not enabled");
	gpg_pwdn_a: assert property (
		(wr_go && wb_adr_i == 8'h08) |=> (gpg_pwdn == $past(wb_dat_i[1])))
		else $error("general group power-down write not applied");

	// Guards for the other strap level, pad power after reset, reserved codes and Ethernet selects
	gpg_gpio_a: assert property (
		(!strap_r && strap_cap_r) [*2] |->
		(small_ctl.gpg_gpio == 4'hF && small_ctl.gpg_pci == 4'h0))
		else $error("general group not routed to GPIO");
	gpg_pull_off_a: assert property (
		(strap_r && strap_cap_r) [*2] |->
		(small_ctl.gpg_pull_en == 4'h0))
		else $error("general group pulls not disabled");
	pad_power_rst_a: assert property (
		$rose(strap_cap_r) |->
		(!host_pwdn && !gpg_pwdn))
		else $error("pads not powered up after reset");
	pci_no_eth_a: assert property (
		(strap_cap_r && strap_r) |=>
		(!eth_mii_sel && host_mux.eth == '0))
		else $error("Ethernet pins selected with strap high");
	eth_mii_on_a: assert property (
		(strap_cap_r && !strap_r && hsel_r == 3'h4) |=>
		(eth_mii_sel && host_mux.sel == '0))
		else $error("Ethernet pin set not selected");
	rsvd_park_a: assert property (
		(strap_cap_r && (strap_r ? hsel_r != 3'h0 : hsel_r > 3'h4)) |=>
		(host_mux == '0 && !eth_mii_sel))
		else $error("reserved select code not parked");
	mac_fault_a: assert property (
		(wr_go && eth_on_nxt && !eth_mac_in_reset &&
		(wb_adr_i == 8'h00 || wb_adr_i == 8'h04)) |=> fault_r)
		else $error("Ethernet selection with MAC running not flagged");
	rmii_sel_a: assert property (
		(wr_go && wb_adr_i == 8'h04) |=> ##1
		(eth_rmii_sel == $past(wb_dat_i[0], 2)))
		else $error("reduced-MII select not applied");

endmodule

// ### hdl/hpm_pkg.sv
// Purpose: Shared constants and carrier types for the host/PCI/GPIO pin mux.
// Assumes: 32-bit classic Wishbone register access, byte addresses.
// Notes:   Host pad index i corresponds to general-purpose line GP[57+i].
package hpm_pkg;

	// Pad counts of the three groups
	localparam int HOST_PINS = 27;
	localparam int PCID_PINS = 3;
	localparam int GPG_PINS  = 4;

	// Register byte offsets
	localparam logic [7:0] SEL_ONE_ADDR  = 8'h00;
	localparam logic [7:0] SEL_ZERO_ADDR = 8'h04;
	localparam logic [7:0] PWDN_ADDR     = 8'h08;
	localparam logic [7:0] STAT_ADDR     = 8'h0C;

	// Field positions in pin_select_reg_one
	localparam int STRAP_BIT = 0;
	localparam int HSEL_LSB  = 1;
	localparam int HSEL_MSB  = 3;
	// Field position in pin_select_reg_zero (reduced-MII enable)
	localparam int RMII_BIT  = 0;
	// Field positions in io_pad_power_down
	localparam int PWDN_HOST_BIT = 0;
	localparam int PWDN_GPG_BIT  = 1;
	// Field positions in the status register
	localparam int STATE_LSB = 0;
	localparam int STATE_MSB = 6;
	localparam int FAULT_BIT = 8;

	// Reset values
	localparam logic [2:0] HSEL_RST = 3'h0;
	localparam logic       RMII_RST = 1'b0;
	localparam logic [1:0] PWDN_RST = 2'h0;

	// Host group select codes
	localparam logic [2:0] HSEL_BASE    = 3'h0;
	localparam logic [2:0] HSEL_HPP     = 3'h1;
	localparam logic [2:0] HSEL_SEL     = 3'h2;
	localparam logic [2:0] HSEL_SEL_ETH = 3'h3;
	localparam logic [2:0] HSEL_ETH     = 3'h4;

	// Host pad masks: all pads, parallel port pads, serial link pads, Ethernet pads
	localparam logic [26:0] MASK_ALL = 27'h7FF_FFFF;
	localparam logic [26:0] MASK_HPP = 27'h7FF_FFFE;
	localparam logic [26:0] MASK_SEL = 27'h000_03FF;
	localparam logic [26:0] MASK_ETH = 27'h7FF_FC00;

	// Host group function, one-hot
	typedef enum logic [6:0] {
		HF_PCI     = 7'h01,
		HF_GPIO    = 7'h02,
		HF_HPP     = 7'h04,
		HF_SEL     = 7'h08,
		HF_SEL_ETH = 7'h10,
		HF_ETH     = 7'h20,
		HF_RSVD    = 7'h40
	} hpm_hfunc_t;

	// Per-pad function selects for the host group, one bit per pad
	typedef struct packed {
		logic [26:0] pci;
		logic [26:0] hpp;
		logic [26:0] sel;
		logic [26:0] eth;
		logic [26:0] gpio;
	} hpm_host_t;

	// Controls for the small PCI data and general-purpose groups
	typedef struct packed {
		logic       pcid_pull_en;
		logic [3:0] gpg_pci;
		logic [3:0] gpg_gpio;
		logic [3:0] gpg_pull_en;
	} hpm_small_t;

endpackage

// ### tb/hpm_strap_model.sv
// Purpose: Far-side model: PCI strap pin and Ethernet MAC reset state.
// Assumes: The bench sets both levels; the strap is changed only in reset.
// Notes:   Purely level based, no clock needed.
`timescale 1ns/10ps
module hpm_strap_model (
	// Bench requests
	input  wire logic strap_req,
	input  wire logic mac_hold_req,
	// Levels toward the mux
	output logic      pci_strap_pin,
	output logic      eth_mac_in_reset
);
	assign pci_strap_pin = strap_req;
	assign eth_mac_in_reset = mac_hold_req;
endmodule

// ### tb/test_hpm_pin_mux.sv
// Purpose: Self-checking bench for the host/PCI/GPIO pin mux.
// Assumes: Classic Wishbone, ack one cycle after the request is sampled.
// Notes:   Strap changes only while reset is held.
`timescale 1ns/10ps
module test_hpm_pin_mux;
	logic clk, rstn, strap_req, mac_hold_req, strap_pin, mac_rst;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	hpm_pkg::hpm_host_t host_mux;
	hpm_pkg::hpm_small_t small_ctl;
	logic [26:0] host_pull_en;
	logic host_pwdn, gpg_pwdn, eth_mii_sel, eth_rmii_sel;
	int mismatches, total_checks;

	hpm_strap_model model (.strap_req(strap_req), .mac_hold_req(mac_hold_req),
		.pci_strap_pin(strap_pin), .eth_mac_in_reset(mac_rst));
	hpm_pin_mux dut (.clk(clk), .rstn(rstn), .pci_strap_pin(strap_pin),
		.eth_mac_in_reset(mac_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.host_mux(host_mux), .host_pull_en(host_pull_en), .host_pwdn(host_pwdn),
		.small_ctl(small_ctl), .gpg_pwdn(gpg_pwdn), .eth_mii_sel(eth_mii_sel),
		.eth_rmii_sel(eth_rmii_sel));

	// Clock, 20 ns period
	always #10 clk = ~clk;

	// Word compare
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Host group select compare
	task automatic chk_host(input hpm_pkg::hpm_host_t got, input hpm_pkg::hpm_host_t exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One classic Wishbone access, held until ack
	task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, wb_ack_o, 1'b1);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	// Reset with a chosen strap level
	task automatic do_reset(input logic s);
		rstn      <= 1'b0;
		strap_req <= s;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// Expected host pad selects per strap and code
	function automatic hpm_pkg::hpm_host_t exp_host(input logic s, input logic [2:0] c);
		hpm_pkg::hpm_host_t h;
		h = '0;
		if (s) begin
			if (c == 3'h0) h.pci = hpm_pkg::MASK_ALL;
		end else begin
			case (c)
				3'h0: h.gpio = hpm_pkg::MASK_ALL;
				3'h1: begin h.hpp = hpm_pkg::MASK_HPP; h.gpio = ~hpm_pkg::MASK_HPP; end
				3'h2: begin h.sel = hpm_pkg::MASK_SEL; h.gpio = ~hpm_pkg::MASK_SEL; end
				3'h3: begin h.sel = hpm_pkg::MASK_SEL; h.eth = hpm_pkg::MASK_ETH; end
				3'h4: begin h.eth = hpm_pkg::MASK_ETH; h.gpio = hpm_pkg::MASK_SEL; end
				default: h = '0;
			endcase
		end
		return h;
	endfunction

	// Pull and small group state for a strap level
	task automatic chk_static(input logic s);
		chk_word({5'h00, host_pull_en}, s ? 32'h0000_0000 : 32'h07FF_FFFF);
		chk_word({31'h0, small_ctl.pcid_pull_en}, {31'h0, ~s});
		chk_word({28'h0, small_ctl.gpg_pci}, s ? 32'h0000_000F : 32'h0000_0000);
		chk_word({28'h0, small_ctl.gpg_gpio}, s ? 32'h0000_0000 : 32'h0000_000F);
		chk_word({28'h0, small_ctl.gpg_pull_en}, s ? 32'h0000_0000 : 32'h0000_000F);
	endtask

	// Strap low: select codes 0 to 5 incl. reserved code 5, strap field stays read-only
	task automatic t_codes_strap_low;
		logic [6:0] fn [6] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
		do_reset(1'b0);
		chk_static(1'b0);
		for (int c = 0; c < 6; c++) begin
			wb_io(1'b1, hpm_pkg::SEL_ONE_ADDR, {28'h000_0000, c[2:0], 1'b1});
			repeat (2) @(posedge clk);
			chk_host(host_mux, exp_host(1'b0, c[2:0]));
			chk_word({31'h0, eth_mii_sel}, {31'h0, c == 3 || c == 4});
			wb_io(1'b0, hpm_pkg::SEL_ONE_ADDR, 32'h0000_0000);
			chk_word(rd, {28'h000_0000, c[2:0], 1'b0});
			wb_io(1'b0, hpm_pkg::STAT_ADDR, 32'h0000_0000);
			chk_word(rd & 32'h0000_007F, {25'h0, fn[c]});
		end
	endtask

	// Power-down fields: reset values and register read, two writes checked at the outputs; reduced-MII select; unmapped read
	task automatic t_pwdn_rmii;
		chk_word({30'h0, gpg_pwdn, host_pwdn}, 32'h0000_0000);
		wb_io(1'b0, hpm_pkg::PWDN_ADDR, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000);
		wb_io(1'b1, hpm_pkg::PWDN_ADDR, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk_word({30'h0, gpg_pwdn, host_pwdn}, 32'h0000_0003);
		wb_io(1'b1, hpm_pkg::PWDN_ADDR, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk_word({30'h0, gpg_pwdn, host_pwdn}, 32'h0000_0002);
		wb_io(1'b1, hpm_pkg::SEL_ZERO_ADDR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk_word({31'h0, eth_rmii_sel}, 32'h0000_0001);
		wb_io(1'b0, 8'h40, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000);
	endtask

	// MAC running: selecting Ethernet pins sets the sticky fault, a write of one clears it
	task automatic t_mac_fault;
		mac_hold_req <= 1'b0;
		wb_io(1'b1, hpm_pkg::SEL_ZERO_ADDR, 32'h0000_0000);
		wb_io(1'b0, hpm_pkg::STAT_ADDR, 32'h0000_0000);
		chk_word(rd, 32'h0000_0040);
		wb_io(1'b1, hpm_pkg::SEL_ONE_ADDR, 32'h0000_0008);
		wb_io(1'b0, hpm_pkg::STAT_ADDR, 32'h0000_0000);
		chk_word(rd, 32'h0000_0120);
		wb_io(1'b1, hpm_pkg::STAT_ADDR, 32'h0000_0100);
		wb_io(1'b0, hpm_pkg::STAT_ADDR, 32'h0000_0000);
		chk_word(rd, 32'h0000_0020);
		chk_word({31'h0, eth_mii_sel}, 32'h0000_0001);
		mac_hold_req <= 1'b1;
	endtask

	// Strap high: PCI on every pad, pulls off, reads back strap bit
	task automatic t_strap_high;
		do_reset(1'b1);
		chk_host(host_mux, exp_host(1'b1, 3'h0));
		chk_static(1'b1);
		chk_word({30'h0, gpg_pwdn, host_pwdn}, 32'h0000_0000);
		wb_io(1'b1, hpm_pkg::SEL_ONE_ADDR, 32'h0000_0000);
		wb_io(1'b0, hpm_pkg::SEL_ONE_ADDR, 32'h0000_0000);
		chk_word(rd, 32'h0000_0001);
		wb_io(1'b1, hpm_pkg::SEL_ONE_ADDR, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk_host(host_mux, exp_host(1'b1, 3'h1));
	endtask

	// Closing report
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		conclude();
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		strap_req = 1'b0;
		mac_hold_req = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		mismatches = 0;
		total_checks = 0;
		t_codes_strap_low();
		t_pwdn_rmii();
		t_mac_fault();
		t_strap_high();
		conclude();
	end
endmodule
